// file: src/bgdebug_consts.svh
// Offsets, field positions and timing counts of the debug unit
`ifndef BGDEBUG_CONSTS_SVH
`define BGDEBUG_CONSTS_SVH
`define OFS_COMMAND 16'hFF00
`define OFS_STATUS 16'hFF01
`define OFS_SHIFT_HI 16'hFF02
`define OFS_SHIFT_LO 16'hFF03
`define OFS_ADDR_HI 16'hFF04
`define OFS_ADDR_LO 16'hFF05
`define OFS_SAVED 16'hFF06
`define MAP_BASE 16'hFF00
`define ST_PERMIT 7
`define ST_ACTIVE 6
`define ST_TAG 5
`define ST_VALID 4
`define ST_STEP 3
`define ST_CLKSEL 2
`define CMD_HWFW 7
`define CMD_DATA 6
`define CMD_RW 5
`define CMD_HALT 4
`define CMD_WORD 3
`define CMD_MAP 2
`define ACTIVE_DELAY 4
`define TAG_DELAY 16
`define IDLE_LIMIT 512
`endif

// file: src/bgdebug_pkg.sv
// Types of the background debug register unit
package bgdebug_pkg;
    typedef enum logic [1:0] {
        RES_NONE = 2'h0,
        RES_GO = 2'h1,
        RES_STEP = 2'h2,
        RES_TAG = 2'h3
    } resume_t;
    typedef enum logic [2:0] {
        REG_NONE0 = 3'h0,
        REG_NONE1 = 3'h1,
        REG_NEXT = 3'h2,
        REG_PC = 3'h3,
        REG_ACC = 3'h4,
        REG_IX = 3'h5,
        REG_IY = 3'h6,
        REG_SP = 3'h7
    } reg_sel_t;
    typedef enum logic [1:0] {
        TAG_IDLE = 2'h0,
        TAG_WAIT = 2'h1,
        TAG_ON = 2'h3
    } tag_state_t;
endpackage

// file: src/background_debug_registers.sv
// Register set and command decode of the single-pin background debug unit
`include "bgdebug_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module background_debug_registers (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic special_mode,
    input wire logic periph_mode,
    input wire logic base_tick,
    input wire logic bus_tick,
    input wire logic bus_slower,
    input wire logic pin_fall,
    input wire logic serial_cmd_load,
    input wire logic [7:0] serial_cmd,
    input wire logic shift_load,
    input wire logic [15:0] shift_data,
    input wire logic shift_done,
    input wire logic shift_start,
    input wire logic addr_load,
    input wire logic [15:0] addr_data,
    input wire logic enter_req,
    input wire logic [7:0] condition_flags,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [15:0] index_x,
    output logic [7:0] bus_rdata,
    output logic map_enable,
    output logic tag_active,
    output logic serial_enable,
    output logic debug_tick,
    output logic halt_cmd,
    output logic resume_go,
    output logic single_step_cmd,
    output logic tag_resume_cmd,
    output logic [2:0] target_reg,
    output logic word_xfer,
    output logic hw_map_flag,
    output logic [15:0] next_index_x
);
    import bgdebug_pkg::*;

    typedef struct packed {
        logic [7:0] command;
        logic permit;
        logic active;
        logic tag_enable;
        logic shift_valid;
        logic step_flag;
        logic clock_select;
        logic [2:0] act_cnt;
        logic act_pend;
        logic act_val;
        logic [4:0] tag_cnt;
        tag_state_t tag_state;
        logic [9:0] idle_cnt;
        logic [15:0] shifter;
        logic [15:0] address;
        logic [7:0] saved_flags;
        logic [7:0] rdata;
        logic tick;
        logic halt;
        logic go;
        logic step;
        logic tagcmd;
        logic [15:0] nx;
        logic tag_on;
        logic ser_en;
        logic hw_map;
    } state_t;

    state_t st;
    state_t nx_st;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        hit = bus_sel && st.active && a == o;
    endfunction

    logic [7:0] status_byte;
    logic use_bus;
    logic take_cmd;
    assign status_byte = {st.permit, st.active, st.tag_enable,
        st.shift_valid, st.step_flag, st.clock_select, 2'h0};
    assign use_bus = st.clock_select || bus_slower;
    assign take_cmd = serial_cmd_load && st.tag_state != TAG_ON;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nx_st = st;
        nx_st.tick = use_bus ? bus_tick : base_tick;
        nx_st.halt = 1'b0;
        nx_st.go = 1'b0;
        nx_st.step = 1'b0;
        nx_st.tagcmd = 1'b0;
        // serial load of the command register
        if (take_cmd) begin
            nx_st.command = serial_cmd;
            if (serial_cmd[`CMD_HWFW] && serial_cmd[`CMD_HALT]) begin
                nx_st.halt = 1'b1;
            end
            if (!serial_cmd[`CMD_HWFW]) begin
                unique case (resume_t'(serial_cmd[4:3]))
                    RES_GO: nx_st.go = 1'b1;
                    RES_STEP: begin
                        nx_st.step = 1'b1;
                        nx_st.step_flag = 1'b1;
                    end
                    RES_TAG: begin
                        nx_st.tagcmd = 1'b1;
                        nx_st.tag_enable = 1'b1;
                        nx_st.tag_state = TAG_WAIT;
                        nx_st.tag_cnt = 5'h0;
                    end
                    RES_NONE: nx_st.go = 1'b0;
                endcase
            end
        end
        if (pin_fall) begin
            nx_st.idle_cnt = 10'h0;
        end else if (base_tick) begin
            if (st.idle_cnt == 10'(`IDLE_LIMIT - 1)) begin
                nx_st.command = 8'h00;
                nx_st.idle_cnt = 10'h0;
            end else begin
                nx_st.idle_cnt = st.idle_cnt + 10'h1;
            end
        end
        if (shift_start) begin
            nx_st.shift_valid = 1'b0;
        end
        if (shift_done) begin
            nx_st.shift_valid = 1'b1;
        end
        // shifter loaded from the serial side
        if (shift_load) begin
            nx_st.shifter = shift_data;
        end
        if (addr_load) begin
            nx_st.address = addr_data;
        end
        // tagging starts sixteen cycles after the write
        if (st.tag_state == TAG_WAIT) begin
            if (st.tag_cnt == 5'(`TAG_DELAY - 1)) begin
                nx_st.tag_state = TAG_ON;
            end else begin
                nx_st.tag_cnt = st.tag_cnt + 5'h1;
            end
        end
        // delayed write of the active bit
        if (st.act_pend) begin
            if (st.act_cnt == 3'(`ACTIVE_DELAY - 1)) begin
                nx_st.active = st.act_val;
                nx_st.act_pend = 1'b0;
            end else begin
                nx_st.act_cnt = st.act_cnt + 3'h1;
            end
        end
        // Parallel bus writes
        if (bus_wr) begin
            if (periph_mode && hit(bus_addr, `OFS_COMMAND)) begin
                nx_st.command = bus_wdata;
            end
            if (hit(bus_addr, `OFS_STATUS)) begin
                nx_st.permit = bus_wdata[`ST_PERMIT];
                // Hardware set events win over a same-cycle clear
                nx_st.tag_enable = bus_wdata[`ST_TAG] || nx_st.tagcmd;
                nx_st.shift_valid = bus_wdata[`ST_VALID] || shift_done;
                nx_st.step_flag = bus_wdata[`ST_STEP] || nx_st.step;
                if (bus_wdata[`ST_TAG] && !st.tag_enable) begin
                    nx_st.tag_state = TAG_WAIT;
                    nx_st.tag_cnt = 5'h0;
                end
                if (!bus_wdata[`ST_TAG] && !nx_st.tagcmd) begin
                    nx_st.tag_state = TAG_IDLE;
                end
                if (!st.command[`CMD_HWFW]) begin
                    nx_st.act_pend = 1'b1;
                    nx_st.act_cnt = 3'h0;
                    nx_st.act_val = bus_wdata[`ST_ACTIVE];
                end else begin
                    nx_st.clock_select = bus_wdata[`ST_CLKSEL];
                end
            end
            if (hit(bus_addr, `OFS_SHIFT_HI)) begin
                nx_st.shifter[15:8] = bus_wdata;
            end
            if (hit(bus_addr, `OFS_SHIFT_LO)) begin
                nx_st.shifter[7:0] = bus_wdata;
            end
            if (hit(bus_addr, `OFS_SAVED)) begin
                nx_st.saved_flags = bus_wdata;
            end
        end
        if (enter_req && st.permit) begin
            nx_st.active = 1'b1;
            nx_st.act_pend = 1'b0;
            nx_st.tag_enable = 1'b0;
            nx_st.tag_state = TAG_IDLE;
            nx_st.saved_flags = condition_flags;
        end
        // Read data, unmapped reads return zero
        nx_st.rdata = 8'h00;
        if (bus_sel && !bus_wr && st.active) begin
            unique case (bus_addr)
                `OFS_COMMAND: nx_st.rdata = st.command;
                `OFS_STATUS: nx_st.rdata = status_byte;
                `OFS_SHIFT_HI: nx_st.rdata = st.shifter[15:8];
                `OFS_SHIFT_LO: nx_st.rdata = st.shifter[7:0];
                `OFS_ADDR_HI: nx_st.rdata = st.address[15:8];
                `OFS_ADDR_LO: nx_st.rdata = st.address[7:0];
                `OFS_SAVED: nx_st.rdata = st.saved_flags;
                default: nx_st.rdata = 8'h00;
            endcase
        end
        // next word address is X plus two
        nx_st.nx = index_x + 16'h0002;
        // Decoded outputs leave through their own flip-flops
        nx_st.tag_on = nx_st.tag_state == TAG_ON;
        nx_st.ser_en = nx_st.tag_state != TAG_ON;
        nx_st.hw_map = nx_st.command[`CMD_HWFW] && nx_st.command[`CMD_MAP];
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= nx_st;
            st.command <= 8'h00;
            st.permit <= 1'b0;
            // Special single-chip and peripheral modes start active
            st.active <= special_mode || periph_mode;
            st.tag_enable <= 1'b0;
            st.shift_valid <= 1'b0;
            st.step_flag <= 1'b0;
            st.clock_select <= 1'b0;
            st.act_cnt <= 3'h0;
            st.act_pend <= 1'b0;
            st.act_val <= 1'b0;
            st.tag_cnt <= 5'h0;
            st.tag_state <= TAG_IDLE;
            st.idle_cnt <= 10'h0;
            st.rdata <= 8'h00;
            st.tick <= 1'b0;
            st.halt <= 1'b0;
            st.go <= 1'b0;
            st.step <= 1'b0;
            st.tagcmd <= 1'b0;
            st.nx <= 16'h0000;
            st.tag_on <= 1'b0;
            st.ser_en <= 1'b1;
            st.hw_map <= 1'b0;
            st.shifter <= 16'h0000;
            st.address <= 16'h0000;
            st.saved_flags <= 8'h00;
        end else begin
            st <= nx_st;
        end
    end

    assign bus_rdata = st.rdata;
    // debug space mapped only while active
    assign map_enable = st.active;
    assign tag_active = st.tag_on;
    assign serial_enable = st.ser_en;
    assign debug_tick = st.tick;
    assign halt_cmd = st.halt;
    assign resume_go = st.go;
    assign single_step_cmd = st.step;
    assign tag_resume_cmd = st.tagcmd;
    assign target_reg = st.command[2:0];
    assign word_xfer = st.command[`CMD_WORD];
    assign hw_map_flag = st.hw_map;
    assign next_index_x = st.nx;

    // ****************************************
    // Assertions
    // ****************************************
    a_active_delay: assert property (@(posedge clk_sys) disable iff (srst)
        st.act_pend && st.act_cnt == 3'h0 && !enter_req ##1 !enter_req
        |-> st.act_pend ##1 st.act_pend)
        else $error("active write landed early");
    a_tag_delay: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(st.tag_state == TAG_WAIT) |-> !tag_active [*8])
        else $error("tagging started too soon");
    a_tag_clear: assert property (@(posedge clk_sys) disable iff (srst)
        enter_req && st.permit |=> !st.tag_enable)
        else $error("tag_enable not cleared on entry");
    a_permit_block: assert property (@(posedge clk_sys) disable iff (srst)
        enter_req && !st.permit && !st.active && !st.act_pend
        |=> !st.active) else $error("entered without permit");
    a_no_serial: assert property (@(posedge clk_sys) disable iff (srst)
        tag_active && serial_cmd_load |=> $stable(st.command) || $past(bus_wr)
        || $past(base_tick)) else $error("command taken while tagging");
    a_step_flag: assert property (@(posedge clk_sys) disable iff (srst)
        single_step_cmd |-> st.step_flag) else $error("step flag missing");
    a_status_low: assert property (@(posedge clk_sys) disable iff (srst)
        bus_sel && !bus_wr && st.active && bus_addr == `OFS_STATUS
        |=> bus_rdata[1:0] == 2'h0) else $error("status low bits nonzero");
    a_next_x: assert property (@(posedge clk_sys) disable iff (srst)
        !srst |=> next_index_x == $past(index_x) + 16'h0002)
        else $error("next address wrong");
    a_clk_sel: assert property (@(posedge clk_sys) disable iff (srst)
        !srst && bus_slower |=> debug_tick == $past(bus_tick))
        else $error("slow bus clock not forced");
    c_enter: cover property (@(posedge clk_sys) enter_req && st.permit);
    c_tag_on: cover property (@(posedge clk_sys) $rose(tag_active));
    c_idle_clr: cover property (@(posedge clk_sys)
        base_tick && st.idle_cnt == 10'(`IDLE_LIMIT - 1));
endmodule
`default_nettype wire

// file: verification/debug_host_model.sv
// Debug host model issuing commands on the serial pin side
`timescale 1ns/1ns
`default_nettype none
module debug_host_model #(
    parameter int GAP = 3
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic send,
    input wire logic slow,
    input wire logic [7:0] cmd,
    output logic pin_fall,
    output logic serial_cmd_load,
    output logic [7:0] serial_cmd,
    output logic busy
);
    int cnt;
    logic [7:0] held;
    always @(posedge clk_sys) begin
        pin_fall <= 1'b0;
        serial_cmd_load <= 1'b0;
        // Released data lines show a changing pattern
        serial_cmd <= ~serial_cmd;
        if (srst) begin
            cnt <= 0;
            busy <= 1'b0;
            serial_cmd <= 8'h00;
        end else if (send && !busy) begin
            held <= cmd;
            pin_fall <= 1'b1;
            busy <= 1'b1;
            cnt <= slow ? 4 * GAP : 2 * GAP;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == GAP + 1) begin
                serial_cmd_load <= 1'b1;
                serial_cmd <= held;
            end
            if (cnt == 1) begin
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/tb_background_debug_registers.sv
// Self-checking bench for the debug register unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); end end
module tb_background_debug_registers;
    logic clk_sys = 1'b0, srst = 1'b1, special_mode = 1'b1, periph_mode = 1'b1;
    logic base_tick = 1'b0, bus_tick = 1'b0, bus_slower = 1'b0, send = 1'b0;
    logic shift_load = 1'b0, shift_done = 1'b0, shift_start = 1'b0;
    logic addr_load = 1'b0, enter_req = 1'b0, bus_sel = 1'b0, bus_wr = 1'b0;
    logic slow = 1'b0;
    logic [7:0] condition_flags = 8'h00, bus_wdata = 8'h00, cmd = 8'h00;
    logic [15:0] shift_data = 16'h0000, addr_data = 16'h0000;
    logic [15:0] bus_addr = 16'h0000, index_x = 16'h0000;
    logic [7:0] bus_rdata, serial_cmd, d;
    logic map_enable, tag_active, serial_enable, debug_tick, halt_cmd;
    logic resume_go, single_step_cmd, tag_resume_cmd, word_xfer, hw_map_flag;
    logic pin_fall, serial_cmd_load, busy;
    logic [2:0] target_reg;
    logic [15:0] next_index_x;
    logic [3:0] s;
    int n_fail = 0, n_compared = 0, c0, c1;
    always #10 clk_sys = ~clk_sys;
    background_debug_registers u_background_debug_registers (.clk_sys, .srst,
        .special_mode, .periph_mode, .base_tick, .bus_tick, .bus_slower,
        .pin_fall, .serial_cmd_load, .serial_cmd, .shift_load, .shift_data,
        .shift_done, .shift_start, .addr_load, .addr_data, .enter_req,
        .condition_flags, .bus_sel, .bus_wr, .bus_addr, .bus_wdata, .index_x,
        .bus_rdata, .map_enable, .tag_active, .serial_enable, .debug_tick,
        .halt_cmd, .resume_go, .single_step_cmd, .tag_resume_cmd, .target_reg,
        .word_xfer, .hw_map_flag, .next_index_x);
    debug_host_model u_debug_host_model (.clk_sys, .srst, .send, .slow, .cmd,
        .pin_fall, .serial_cmd_load, .serial_cmd, .busy);
    // ****************************************
    // Bus, host and tick tasks
    // ****************************************
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic bus_w(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_sel <= 1'b1;
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge clk_sys);
        bus_sel <= 1'b0;
        bus_wr <= 1'b0;
    endtask
    task automatic bus_r(input logic [15:0] a, output logic [7:0] v);
        v = 8'h00;
        @(posedge clk_sys);
        bus_sel <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_sel <= 1'b0;
        repeat (3) begin
            #1 v = v | bus_rdata;
            @(posedge clk_sys);
        end
    endtask
    task automatic host_cmd(input logic [7:0] c, output logic [3:0] v);
        v = 4'h0;
        @(posedge clk_sys);
        send <= 1'b1;
        cmd <= c;
        @(posedge clk_sys);
        send <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            #1 v = v | {halt_cmd, resume_go, single_step_cmd, tag_resume_cmd};
            if (!busy && i > 2) return;
        end
        n_fail++;
        tally_and_finish();
    endtask
    task automatic dt(input logic b, input logic e, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk_sys);
        base_tick <= b;
        bus_tick <= e;
        @(posedge clk_sys);
        base_tick <= 1'b0;
        bus_tick <= 1'b0;
        repeat (3) begin
            #1 seen = seen | debug_tick;
            @(posedge clk_sys);
        end
        `CHK(seen, exp)
    endtask
    task automatic pulse_enter(input logic [7:0] f);
        @(posedge clk_sys);
        enter_req <= 1'b1;
        condition_flags <= f;
        @(posedge clk_sys);
        enter_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_entry();
        bus_w(16'hFF01, 8'h00);
        repeat (6) @(posedge clk_sys);
        pulse_enter(8'h11);
        `CHK(map_enable, 1'b0)
        `CHK(serial_enable, 1'b1)
        host_cmd(8'h90, s);
        `CHK(s[3], 1'b1)
        bus_r(16'hFF01, d);
        `CHK(d, 8'h00)
        // Reset in mid-run: special modes restart in active mode
        srst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        #1 `CHK(map_enable, 1'b1)
        bus_w(16'hFF01, 8'hC0);
        pulse_enter(8'hA5);
        `CHK(map_enable, 1'b1)
        bus_r(16'hFF01, d);
        `CHK(d[7:6], 2'b11)
        bus_r(16'hFF06, d);
        `CHK(d, 8'hA5)
        bus_w(16'hFF06, 8'h3C);
        bus_r(16'hFF06, d);
        `CHK(d, 8'h3C)
    endtask
    task automatic t_regs();
        @(posedge clk_sys);
        addr_load <= 1'b1;
        addr_data <= 16'h1234;
        shift_start <= 1'b1;
        @(posedge clk_sys);
        addr_load <= 1'b0;
        shift_start <= 1'b0;
        bus_r(16'hFF01, d);
        `CHK(d[4], 1'b0)
        shift_load <= 1'b1;
        shift_data <= 16'hBEEF;
        @(posedge clk_sys);
        shift_load <= 1'b0;
        shift_done <= 1'b1;
        @(posedge clk_sys);
        shift_done <= 1'b0;
        bus_r(16'hFF01, d);
        `CHK(d[4], 1'b1)
        bus_r(16'hFF02, d);
        `CHK(d, 8'hBE)
        bus_r(16'hFF03, d);
        `CHK(d, 8'hEF)
        bus_w(16'hFF04, 8'h55);
        bus_r(16'hFF04, d);
        `CHK(d, 8'h12)
        bus_r(16'hFF05, d);
        `CHK(d, 8'h34)
        bus_w(16'hFF02, 8'h77);
        bus_r(16'hFF02, d);
        `CHK(d, 8'h77)
        bus_r(16'hFF07, d);
        `CHK(d, 8'h00)
        bus_w(16'hFF01, 8'hC3);
        bus_r(16'hFF01, d);
        `CHK(d[1:0], 2'b00)
    endtask
    task automatic t_cmds();
        host_cmd(8'h08, s);
        `CHK(s, 4'h4)
        host_cmd(8'h10, s);
        `CHK(s, 4'h2)
        bus_r(16'hFF01, d);
        `CHK(d[3], 1'b1)
        host_cmd(8'h00, s);
        `CHK(s, 4'h0)
        for (int r = 2; r < 8; r++) begin
            host_cmd(8'h60 | 8'(r), s);
            `CHK(target_reg, 3'(r))
        end
        index_x <= 16'h1FFE;
        host_cmd(8'h62, s);
        `CHK(next_index_x, 16'h2000)
        bus_r(16'hFF00, d);
        `CHK(d, 8'h62)
        slow <= 1'b1;
        host_cmd(8'h9C, s);
        slow <= 1'b0;
        `CHK(s, 4'h8)
        `CHK({word_xfer, hw_map_flag}, 2'b11)
        bus_r(16'hFF00, d);
        `CHK(d[7], 1'b1)
        host_cmd(8'h90, s);
        `CHK({word_xfer, hw_map_flag}, 2'b00)
    endtask
    task automatic t_watchdog();
        bus_w(16'hFF00, 8'h44);
        for (int i = 0; i < 520; i++) begin
            if (i == 500) begin
                bus_r(16'hFF00, d);
                `CHK(d, 8'h44)
            end
            dt(1'b1, 1'b0, 1'b1);
        end
        bus_r(16'hFF00, d);
        `CHK(d, 8'h00)
    endtask
    task automatic t_clock();
        bus_w(16'hFF00, 8'h80);
        bus_w(16'hFF01, 8'h84);
        repeat (8) @(posedge clk_sys);
        #1 `CHK(map_enable, 1'b1)
        bus_r(16'hFF01, d);
        `CHK(d[2], 1'b1)
        dt(1'b0, 1'b1, 1'b1);
        dt(1'b1, 1'b0, 1'b0);
        bus_w(16'hFF01, 8'h80);
        bus_slower <= 1'b1;
        dt(1'b1, 1'b0, 1'b0);
        dt(1'b0, 1'b1, 1'b1);
        bus_slower <= 1'b0;
        dt(1'b1, 1'b0, 1'b1);
    endtask
    task automatic t_tag();
        c0 = 0;
        c1 = 0;
        s = 4'h0;
        @(posedge clk_sys);
        send <= 1'b1;
        cmd <= 8'h18;
        @(posedge clk_sys);
        send <= 1'b0;
        for (int i = 1; i < 40; i++) begin
            @(posedge clk_sys);
            #1;
            if (serial_cmd_load) c0 = i + 1;
            if (tag_active && c1 == 0) c1 = i;
            if (tag_resume_cmd) s = 4'h1;
        end
        `CHK(s, 4'h1)
        `CHK(c1 - c0, 16)
        `CHK(serial_enable, 1'b0)
        bus_r(16'hFF01, d);
        `CHK(d[5], 1'b1)
        host_cmd(8'h08, s);
        `CHK(s, 4'h0)
        pulse_enter(8'h00);
        `CHK(tag_active, 1'b0)
        bus_r(16'hFF01, d);
        `CHK(d[5], 1'b0)
    endtask
    task automatic t_exit();
        bus_w(16'hFF00, 8'h00);
        bus_w(16'hFF01, 8'h80);
        c1 = 0;
        for (int i = 1; i < 12; i++) begin
            @(posedge clk_sys);
            #1;
            if (!map_enable && c1 == 0) c1 = i;
        end
        `CHK(c1, 4)
        bus_r(16'hFF01, d);
        `CHK(d, 8'h00)
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        t_entry();
        t_regs();
        t_cmds();
        t_watchdog();
        t_clock();
        t_tag();
        t_exit();
        tally_and_finish();
    end
endmodule
`default_nettype wire
